/* File: lam_core.sv */
/*
 Lane validity flags, activity states and branch stack with condition test.
 Assumes the sequencer resolves the boolean named by flag_constant_index
 into flag_value, and never sets whole_quad and valid_only together.
*/
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
module lam_core (
    // Clock and reset.
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    // Sequencer command and result.
    input  wire lam_pkg::lam_cmd_type CMD,
    output lam_pkg::lam_res_type      RES,
    output logic [3:0]                STACK_DEPTH,
    // APB slave.
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [11:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic [31:0]               PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR
);
    import lam_pkg::*;

    logic                 rst_q1;
    logic                 rst_n;
    logic [LAM_LANES-1:0] lane_valid;
    lam_lane_type         lane_act [LAM_LANES];
    lam_lane_type         shadow [LAM_LANES];
    logic                 shadow_pend;
    logic [2*LAM_LANES-1:0] stack_mem [LAM_DEPTH];
    logic [LAM_SPW-1:0]   sp;
    logic [31:0]          ctrl;
    lam_cmd_type          cmd;
    logic [2*LAM_LANES-1:0] cur_word;
    logic [2*LAM_LANES-1:0] pop_word;
    logic [LAM_SPW-1:0]   pop_idx;
    logic                 pop_ok;
    logic                 pop_first;
    logic [LAM_LANES-1:0] live;
    logic [LAM_LANES-1:0] cur_live;
    logic [LAM_LANES-1:0] pass;
    logic                 any_pass;
    logic                 vpm_eff;
    lam_lane_type         base [LAM_LANES];
    lam_lane_type         upd [LAM_LANES];
    lam_lane_type         pred [LAM_LANES];
    lam_lane_type         cur [LAM_LANES];

    // Reset release through two flip-flops.
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // A held block ignores commands.
    always_comb
    begin
        cmd = CMD;
        if (ctrl[CTRL_HOLD_BIT])
            cmd.op = OP_NONE;
    end

    assign vpm_eff   = cmd.valid_only && cmd.op != OP_ALU;
    assign pop_first = cmd.op == OP_POP_TEST;
    assign pop_ok    = cmd.pop_count != LAM_SP_ZERO && cmd.pop_count <= sp;
    assign pop_idx   = sp - cmd.pop_count;
    assign pop_word  = stack_mem[pop_idx[2:0]];

    genvar g;
    generate
        for (g = 0; g < LAM_LANES; g++)
        begin : g_lane
            localparam int Q = g - (g % LAM_QUAD);
            logic eff;
            // Pending predicate writes become visible at the next CF op.
            assign cur[g] = shadow_pend ? shadow[g] : lane_act[g];
            assign cur_word[2*g+1:2*g] = cur[g];
            assign cur_live[g] = lane_act[g] == LANE_ACTIVE;
            always_comb
            begin
                base[g] = cur[g];
                if (pop_first && pop_ok)
                    base[g] = lam_lane_type'(pop_word[2*g+1:2*g]);
                if (pop_first && cmd.valid_only && !lane_valid[g])
                    base[g] = LANE_BRANCH;
            end
            assign live[g] = base[g] == LANE_ACTIVE;
            always_comb
            begin
                if (cmd.whole_quad && cmd.op != OP_ALU)
                    eff = |live[Q+LAM_QUAD-1:Q];
                else if (vpm_eff)
                    eff = live[g] && lane_valid[g];
                else
                    eff = live[g];
                case (cmd.test_select)
                    TEST_LIVE_AND_FLAG_SET:   pass[g] = eff && cmd.flag_value;
                    TEST_LIVE_AND_FLAG_CLEAR: pass[g] = eff && !cmd.flag_value;
                    default:                  pass[g] = eff;
                endcase
                if (cmd.op == OP_ALU)
                    pass[g] = cur_live[g];
                // Passing lanes go live, even under quad-wide.
                if (pass[g])
                    upd[g] = LANE_ACTIVE;
                else if (live[g])
                    upd[g] = LANE_BRANCH;
                else
                    upd[g] = base[g];
                if (cmd.lane_mask[g] || cur[g] != LANE_ACTIVE)
                    pred[g] = cur[g];
                else
                    pred[g] = cmd.fail_code;
            end
            chk_pred_code: assert property (
                @(posedge CLK) disable iff (!rst_n)
                cmd.op == OP_PRED && !cmd.lane_mask[g] && cur[g] == LANE_ACTIVE
                |=> shadow[g] == $past(cmd.fail_code))
                else $error("predicate fail code not stored");
            chk_quad_same: assert property (
                @(posedge CLK) disable iff (!rst_n)
                cmd.whole_quad && (cmd.op == OP_PLAIN || cmd.op == OP_UPDATE)
                |=> RES.exec_mask[g] == RES.exec_mask[Q])
                else $error("quad lanes differ under whole quad");
        end
    endgenerate

    assign any_pass = |pass;

    // Validity flags.
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            lane_valid <= '0;
        else if (cmd.op == OP_START)
            lane_valid <= cmd.lane_mask;
        else if (cmd.op == OP_KILL)
            lane_valid <= lane_valid & ~cmd.lane_mask;
    end

    // Activity states.
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < LAM_LANES; i++)
                lane_act[i] <= LANE_BRANCH;
        end
        else
        begin
            for (int i = 0; i < LAM_LANES; i++)
            begin
                case (cmd.op)
                    OP_START:
                        lane_act[i] <= cmd.lane_mask[i] ? LANE_ACTIVE
                                                         : LANE_BRANCH;
                    OP_UPDATE, OP_POP_TEST:
                        lane_act[i] <= upd[i];
                    OP_PUSH:
                        if (any_pass)
                            lane_act[i] <= upd[i];
                        else if (pop_ok && cmd.valid_only && !lane_valid[i])
                            lane_act[i] <= LANE_BRANCH;
                        else if (pop_ok)
                            lane_act[i] <= lam_lane_type'(pop_word[2*i +: 2]);
                        else
                            lane_act[i] <= cur[i];
                    OP_PLAIN, OP_KILL:
                        lane_act[i] <= cur[i];
                    default:
                        lane_act[i] <= lane_act[i];
                endcase
            end
        end
    end

    // Predicate writes from an arithmetic clause.
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shadow_pend <= 1'b0;
            for (int i = 0; i < LAM_LANES; i++)
                shadow[i] <= LANE_BRANCH;
        end
        else if (cmd.op == OP_PRED)
        begin
            shadow_pend <= 1'b1;
            for (int i = 0; i < LAM_LANES; i++)
                shadow[i] <= pred[i];
        end
        else if (cmd.op != OP_NONE && cmd.op != OP_ALU)
            shadow_pend <= 1'b0;
    end

    // Branch stack; overflow pushes are dropped.
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            sp <= LAM_SP_ZERO;
        else if (cmd.op == OP_START)
            sp <= LAM_SP_ZERO;
        else if (sp != LAM_SP_FULL &&
                 ((cmd.op == OP_PUSH && any_pass) || cmd.op == OP_PRED))
            sp <= sp + LAM_SP_ONE;
        else if (pop_ok && (pop_first || (cmd.op == OP_PUSH && !any_pass)))
            sp <= pop_idx;
    end

    always_ff @(posedge CLK)
    begin
        if (sp != LAM_SP_FULL &&
            ((cmd.op == OP_PUSH && any_pass) || cmd.op == OP_PRED))
            stack_mem[sp[2:0]] <= cur_word;
    end

    // Registered results to the sequencer.
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            RES <= '0;
        else
        begin
            RES.exec_mask <= (cmd.op == OP_NONE || cmd.op == OP_KILL ||
                              cmd.op == OP_START || cmd.op == OP_PRED)
                             ? '0 : pass;
            RES.jump      <= cmd.op == OP_PUSH && !any_pass;
            RES.any_pass  <= any_pass && cmd.op != OP_NONE;
        end
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
            STACK_DEPTH <= LAM_SP_ZERO;
        else
            STACK_DEPTH <= sp;
    end

    // APB slave: one wait state, error on unmapped addresses.
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
            ctrl    <= CTRL_RESET;
        end
        else
        begin
            PREADY  <= PSEL && PENABLE && !PREADY;
            PSLVERR <= 1'b0;
            PRDATA  <= '0;
            if (PSEL && PENABLE && !PREADY)
            begin
                case (PADDR)
                    ADDR_CTRL:
                        if (PWRITE)
                            ctrl <= PWDATA;
                        else
                            PRDATA <= ctrl;
                    ADDR_STAT:
                        PRDATA <= {28'h0000000, sp};
                    ADDR_LIVE:
                        PRDATA <= {16'h0000, cur_live};
                    ADDR_VALID:
                        PRDATA <= {16'h0000, lane_valid};
                    default:
                        PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    chk_valid_no_rise: assert property (
        @(posedge CLK) disable iff (!rst_n)
        $past(cmd.op) != OP_START |-> (lane_valid & ~$past(lane_valid)) == '0)
        else $error("valid flag rose without a start");
    chk_kill_keeps_act: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_KILL && !shadow_pend |=> cur_live == $past(cur_live))
        else $error("kill changed activity");
    chk_plain_no_change: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_PLAIN && !shadow_pend ##1 cmd.op == OP_NONE
        |-> cur_live == $past(cur_live))
        else $error("plain op changed mask");
    chk_push_depth_up: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_PUSH && any_pass && sp < LAM_SP_FULL
        |=> sp == $past(sp) + LAM_SP_ONE)
        else $error("push did not grow stack");
    chk_push_fail_jump: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_PUSH && !any_pass |=> RES.jump && !RES.any_pass)
        else $error("failing push did not jump");
    chk_start_masks: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_START |=> cur_live == $past(cmd.lane_mask))
        else $error("start mask wrong");
    chk_vpm_pop_kill: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_POP_TEST && cmd.valid_only |=> (cur_live & ~lane_valid) == '0)
        else $error("invalid lane live after pop");
    chk_alu_exec_mask: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_ALU |=> RES.exec_mask == $past(cur_live))
        else $error("alu exec mask wrong");
    chk_pred_hidden: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_PRED |=> shadow_pend && cur_live == $past(cur_live))
        else $error("predicate write visible early");
    chk_pop_depth_down: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_POP_TEST && pop_ok
        |=> sp == $past(sp) - $past(cmd.pop_count))
        else $error("pop did not shrink stack");
    chk_no_pop_keeps: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_PUSH && !any_pass && !pop_ok && !shadow_pend
        |=> cur_live == $past(cur_live) && sp == $past(sp))
        else $error("failed push without pop changed state");
    chk_vpm_pass_valid: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.valid_only && !cmd.whole_quad && cmd.op != OP_ALU
        |=> (RES.exec_mask & ~$past(lane_valid)) == '0)
        else $error("invalid lane passed in valid-only mode");
    chk_push_pop_vpm: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_PUSH && !any_pass && pop_ok && cmd.valid_only
        |=> (cur_live & ~lane_valid) == '0)
        else $error("invalid lane live after failed push");
    chk_alu_keeps_mask: assert property (
        @(posedge CLK) disable iff (!rst_n)
        cmd.op == OP_ALU
        |=> cur_live == $past(cur_live) && shadow_pend == $past(shadow_pend))
        else $error("alu clause changed the mask");
endmodule // lam_core

/* File: lam_pkg.sv */
/*
 Shared constants and types for the lane active-mask control block.
 Assumes a 16-lane processor grouped in 2-by-2 quads and an APB host.
*/
package lam_pkg;
    localparam int LAM_LANES = 16;
    localparam int LAM_QUAD  = 4;
    localparam int LAM_DEPTH = 8;
    localparam int LAM_SPW   = 4;
    localparam logic [LAM_SPW-1:0] LAM_SP_ZERO = 4'h0;
    localparam logic [LAM_SPW-1:0] LAM_SP_ONE  = 4'h1;
    localparam logic [LAM_SPW-1:0] LAM_SP_FULL = 4'h8;
    localparam logic [11:0] ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_STAT  = 12'h004;
    localparam logic [11:0] ADDR_LIVE  = 12'h008;
    localparam logic [11:0] ADDR_VALID = 12'h00C;
    localparam int CTRL_HOLD_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        LANE_ACTIVE   = 2'h0,
        LANE_BRANCH   = 2'h1,
        LANE_CONTINUE = 2'h2,
        LANE_BREAK    = 2'h3
    } lam_lane_type;

    typedef enum logic [1:0] {
        TEST_WHEN_LIVE           = 2'h0,
        TEST_LIVE_AND_FLAG_SET   = 2'h1,
        TEST_LIVE_AND_FLAG_CLEAR = 2'h2
    } lam_test_type;

    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_START    = 4'h1,
        OP_PLAIN    = 4'h2,
        OP_UPDATE   = 4'h3,
        OP_PUSH     = 4'h4,
        OP_POP_TEST = 4'h5,
        OP_KILL     = 4'h6,
        OP_PRED     = 4'h7,
        OP_ALU      = 4'h8
    } lam_op_type;

    typedef struct packed {
        lam_op_type           op;
        logic                 whole_quad;
        logic                 valid_only;
        lam_test_type         test_select;
        logic                 flag_value;
        logic [LAM_SPW-1:0]   pop_count;
        logic [LAM_LANES-1:0] lane_mask;
        lam_lane_type         fail_code;
    } lam_cmd_type;

    typedef struct packed {
        logic [LAM_LANES-1:0] exec_mask;
        logic                 jump;
        logic                 any_pass;
    } lam_res_type;
endpackage

/* File: lam_seq_model.sv */
/*
 Sequencer model that presents one command at a time on the command port.
 Assumes the caller runs from a procedure clocked by the same clock.
*/
`timescale 1ns/1ns
module lam_seq_model (
    // Clock.
    input  wire logic            CLK,
    // Command to the block.
    output lam_pkg::lam_cmd_type CMD
);
    import lam_pkg::*;

    initial CMD = '0;

    // Drives one command for one edge, then returns to idle.
    task automatic issue(input lam_cmd_type c);
        begin
            if (c.whole_quad)
                c.valid_only = 1'h0;
            @(posedge CLK);
            CMD <= c;
            @(posedge CLK);
            CMD <= '0;
        end
    endtask
endmodule // lam_seq_model

/* File: testbench.sv */
/*
 Self-checking testbench for the lane active-mask core.
 Assumes the sequencer model and an APB master made of tasks below.
*/
`timescale 1ns/1ns
module testbench;
    import lam_pkg::*;

    logic                 clk;
    logic                 rst_n;
    lam_cmd_type          cmd;
    lam_res_type          res;
    logic [3:0]           depth;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    int                   fails;
    int                   comparisons;

    lam_seq_model seq (.CLK(clk), .CMD(cmd));

    lam_core uut (
        .CLK(clk), .RST_N(rst_n), .CMD(cmd), .RES(res), .STACK_DEPTH(depth),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
    );

    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                fails++;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic final_report;
        begin
            $display("checks %0d, mismatches %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    // One APB transfer; holds the request until pready is seen at an edge, for at most 50 edges, then counts a failure.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        begin
            n = 0;
            @(posedge clk);
            psel <= 1'h1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge clk);
            penable <= 1'h1;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (pready !== 1'h1 && n < 50);
            if (n >= 50)
                chk(32'h0, 32'h1);
            rd = prdata;
            er = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        begin
            apb(1'h0, a, 32'h0, d, e);
            chk(d, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic        e;
        begin
            apb(1'h1, a, v, d, e);
        end
    endtask

    function automatic lam_cmd_type mk(input lam_op_type o, input logic wq, input logic vo,
                                       input lam_test_type t, input logic f,
                                       input logic [15:0] m);
        lam_cmd_type c;
        begin
            c = '0;
            c.op = o;
            c.whole_quad = wq;
            c.valid_only = vo;
            c.test_select = t;
            c.flag_value = f;
            c.pop_count = (o == OP_POP_TEST) ? LAM_SP_ONE : LAM_SP_ZERO;
            c.lane_mask = m;
            c.fail_code = LANE_BRANCH;
            return c;
        end
    endfunction

    // Issues a command and compares the result word one cycle later.
    task automatic run(input lam_cmd_type c, input logic [15:0] m, input logic j,
                       input logic a);
        begin
            seq.issue(c);
            #1;
            chk({14'h0, res}, {14'h0, m, j, a});
        end
    endtask

    task automatic t_reset;
        logic [31:0] d;
        logic        e;
        begin
            rdchk(ADDR_CTRL, CTRL_RESET);
            rdchk(ADDR_STAT, 32'h0);
            rdchk(ADDR_LIVE, 32'h0);
            rdchk(ADDR_VALID, 32'h0);
            apb(1'h0, 12'h010, 32'h0, d, e);
            chk({e, d[30:0]}, 32'h8000_0000);
            wr(ADDR_STAT, 32'h0000_0005);
            rdchk(ADDR_STAT, 32'h0);
            $display("test reset done");
        end
    endtask

    task automatic t_push;
        begin
            seq.issue(mk(OP_START, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h00FF));
            rdchk(ADDR_VALID, 32'h0000_00FF);
            rdchk(ADDR_LIVE, 32'h0000_00FF);
            run(mk(OP_PUSH, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h00FF, 1'h0, 1'h1);
            @(posedge clk);
            #1;
            chk({28'h0, depth}, 32'h1);
            run(mk(OP_PUSH, 1'h0, 1'h0, TEST_LIVE_AND_FLAG_SET, 1'h0, 16'h0), 16'h0, 1'h1, 1'h0);
            rdchk(ADDR_LIVE, 32'h0000_00FF);
            $display("test push done");
        end
    endtask

    task automatic t_clause;
        begin
            seq.issue(mk(OP_PRED, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0001));
            run(mk(OP_ALU, 1'h0, 1'h0, TEST_LIVE_AND_FLAG_SET, 1'h0, 16'h0), 16'h00FF, 1'h0, 1'h1);
            run(mk(OP_PLAIN, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h0001, 1'h0, 1'h1);
            rdchk(ADDR_STAT, 32'h2);
            rdchk(ADDR_LIVE, 32'h0000_0001);
            run(mk(OP_PLAIN, 1'h1, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h000F, 1'h0, 1'h1);
            rdchk(ADDR_LIVE, 32'h0000_0001);
            run(mk(OP_PLAIN, 1'h1, 1'h0, TEST_LIVE_AND_FLAG_SET, 1'h1, 16'h0), 16'h000F, 1'h0, 1'h1);
            run(mk(OP_UPDATE, 1'h1, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h000F, 1'h0, 1'h1);
            rdchk(ADDR_LIVE, 32'h0000_000F);
            $display("test clause and quad done");
        end
    endtask

    task automatic t_kill_pop;
        begin
            seq.issue(mk(OP_KILL, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0002));
            rdchk(ADDR_VALID, 32'h0000_00FD);
            rdchk(ADDR_LIVE, 32'h0000_000F);
            run(mk(OP_PLAIN, 1'h0, 1'h1, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h000D, 1'h0, 1'h1);
            run(mk(OP_PLAIN, 1'h0, 1'h1, TEST_LIVE_AND_FLAG_SET, 1'h1, 16'h0), 16'h000D, 1'h0, 1'h1);
            run(mk(OP_ALU, 1'h0, 1'h1, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h000F, 1'h0, 1'h1);
            rdchk(ADDR_LIVE, 32'h0000_000F);
            run(mk(OP_POP_TEST, 1'h0, 1'h1, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h00FD, 1'h0, 1'h1);
            rdchk(ADDR_LIVE, 32'h0000_00FD);
            run(mk(OP_POP_TEST, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h00FF, 1'h0, 1'h1);
            rdchk(ADDR_STAT, 32'h0);
            seq.issue(mk(OP_POP_TEST, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0));
            rdchk(ADDR_LIVE, 32'h0000_00FF);
            $display("test kill and pop done");
        end
    endtask

    task automatic t_hold_flags;
        begin
            wr(ADDR_CTRL, 32'h0000_0001);
            run(mk(OP_PUSH, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h0, 1'h0, 1'h0);
            rdchk(ADDR_STAT, 32'h0);
            wr(ADDR_CTRL, 32'h0);
            rdchk(ADDR_CTRL, 32'h0);
            run(mk(OP_PLAIN, 1'h0, 1'h0, TEST_LIVE_AND_FLAG_CLEAR, 1'h0, 16'h0), 16'h00FF, 1'h0, 1'h1);
            run(mk(OP_PLAIN, 1'h0, 1'h0, TEST_LIVE_AND_FLAG_CLEAR, 1'h1, 16'h0), 16'h0, 1'h0, 1'h0);
            run(mk(OP_UPDATE, 1'h0, 1'h0, TEST_LIVE_AND_FLAG_SET, 1'h0, 16'h0), 16'h0, 1'h0, 1'h0);
            rdchk(ADDR_LIVE, 32'h0);
            $display("test hold and flags done");
        end
    endtask

    task automatic t_pops;
        lam_cmd_type c;
        begin
            seq.issue(mk(OP_START, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h00FF));
            seq.issue(mk(OP_KILL, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0002));
            run(mk(OP_PUSH, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h00FF, 1'h0, 1'h1);
            c = mk(OP_PRED, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h00F0);
            c.fail_code = LANE_BREAK;
            seq.issue(c);
            run(mk(OP_PLAIN, 1'h0, 1'h0, TEST_WHEN_LIVE, 1'h0, 16'h0), 16'h00F0, 1'h0, 1'h1);
            rdchk(ADDR_STAT, 32'h2);
            c = mk(OP_PUSH, 1'h0, 1'h1, TEST_LIVE_AND_FLAG_SET, 1'h0, 16'h0);
            c.pop_count = 4'h2;
            run(c, 16'h0, 1'h1, 1'h0);
            rdchk(ADDR_LIVE, 32'h0000_00FD);
            rdchk(ADDR_STAT, 32'h0);
            $display("test multiple pops done");
        end
    endtask

    initial
    begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fails = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        t_reset();
        t_push();
        t_clause();
        t_kill_pop();
        t_hold_flags();
        t_pops();
        final_report();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule // testbench
